// >>> memory_size_config_map.svh
/*
  Addresses, field positions, reset values and decode limits of the
  memory size configuration registers.
  Assumes a 16-bit CPU data address space and byte-wide register stores.
*/
// Operation
// - Memory size select is write-only, loaded by byte store at its address.
// - Reset loads memory size select with full program and fast RAM capacity.
// - Bits 3..0 select 8 to 60 Kbytes program memory; bit 4 is zero.
// - Bits 7..5 select 512 bytes (010) or 1024 bytes (110) fast RAM.
// - Program memory and fast RAM above the chosen capacity are disabled.
// - Expansion RAM size select is write-only, loaded by byte store.
// - Reset loads expansion RAM size select with the full 1024-byte code.
// - Bits 3..0: 1010 full, 1011 upper half, 1100 none; bits 7..4 zero.
// - Expansion RAM beyond the selected capacity is disabled.
`ifndef MEMORY_SIZE_CONFIG_MAP_SVH
`define MEMORY_SIZE_CONFIG_MAP_SVH

`define MEM_SIZE_SEL_ADDR 16'hfff0
`define EXT_SIZE_SEL_ADDR 16'hfff4
`define MEM_SIZE_SEL_RESET 8'hcf
`define EXT_SIZE_SEL_RESET 8'h0a

`define PROG_FIELD_MSB 3
`define PROG_FIELD_LSB 0
`define FAST_FIELD_MSB 7
`define FAST_FIELD_LSB 5
`define EXT_FIELD_MSB 3
`define EXT_FIELD_LSB 0
`define MEM_SIZE_WR_MASK 8'hef
`define EXT_SIZE_WR_MASK 8'h0f

`define FAST_CODE_1024 3'h6
`define FAST_CODE_512 3'h2
`define EXT_CODE_FULL 4'ha
`define EXT_CODE_HALF 4'hb
`define EXT_CODE_NONE 4'hc

`define FAST_MEM_TOP 16'hfeff
`define FAST_BASE_1024 16'hfb00
`define FAST_BASE_512 16'hfd00
`define EXT_BASE_FULL 16'hf400
`define EXT_BASE_HALF 16'hf600
`define EXT_MEM_TOP 16'hf7ff

`endif

// >>> memory_size_config_pkg.sv
/*
  Types shared by the memory size configuration block.
  Assumes the constants header is compiled alongside.
*/
package memory_size_config_pkg;

  typedef struct packed {
    logic en;
    logic byteOp;
    logic [15:0] addr;
    logic [7:0] data;
  } cpu_write_type;

  typedef enum logic [2:0] {
    EXT_FULL = 3'b001,
    EXT_HALF = 3'b010,
    EXT_OFF = 3'b100
  } ext_mode_type;

  typedef struct packed {
    logic [16:0] progLimit;
    logic [15:0] fastBase;
    logic [15:0] extBase;
    logic extOn;
  } capacity_type;

endpackage

// >>> memory_size_config_regs.sv
/*
  Write-only memory size configuration registers and the capacity
  qualifiers they drive for program fetch and data accesses.
  Assumes the CPU presents one store per cycle, synchronous to core_clk,
  and that the memory decoder ANDs its own selects with the hit outputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "memory_size_config_map.svh"

module memory_size_config_regs
  import memory_size_config_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // CPU store port
  input wire cpu_write_type cpuWr,
  // Access addresses to qualify
  input wire logic [15:0] fetchAddr,
  input wire logic [15:0] dataAddr,
  // Register contents
  output logic [7:0] memSizeSel,
  output logic [7:0] extSizeSel,
  // Decoded capacities
  output capacity_type capacity,
  output ext_mode_type extMode,
  // Access qualifiers
  output logic progHit,
  output logic fastMemHit,
  output logic extMemHit
);

  logic [7:0] memSizeSel_r;
  logic [7:0] memSizeSel_nxt;
  logic [7:0] extSizeSel_r;
  logic [7:0] extSizeSel_nxt;

  // Only byte stores at the exact address load a register
  wire logic byteStore = cpuWr.en & cpuWr.byteOp;
  wire logic memSelWr = byteStore & (cpuWr.addr == `MEM_SIZE_SEL_ADDR);
  wire logic extSelWr = byteStore & (cpuWr.addr == `EXT_SIZE_SEL_ADDR);

  // Fixed-zero bits are forced so stray ones never reach the decode
  wire logic [7:0] memSelMasked = cpuWr.data & `MEM_SIZE_WR_MASK;
  wire logic [7:0] extSelMasked = cpuWr.data & `EXT_SIZE_WR_MASK;

  assign memSizeSel_nxt = memSelWr ? memSelMasked : memSizeSel_r;
  assign extSizeSel_nxt = extSelWr ? extSelMasked : extSizeSel_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memSizeSel_r <= `MEM_SIZE_SEL_RESET;
      extSizeSel_r <= `EXT_SIZE_SEL_RESET;
    end else begin
      memSizeSel_r <= memSizeSel_nxt;
      extSizeSel_r <= extSizeSel_nxt;
    end
  end

  assign memSizeSel = memSizeSel_r;
  assign extSizeSel = extSizeSel_r;

  // Field extraction
  wire logic [3:0] progCode = memSizeSel_r[`PROG_FIELD_MSB:`PROG_FIELD_LSB];
  wire logic [2:0] fastCode = memSizeSel_r[`FAST_FIELD_MSB:`FAST_FIELD_LSB];
  wire logic [3:0] extCode = extSizeSel_r[`EXT_FIELD_MSB:`EXT_FIELD_LSB];

  // Program memory size is the code in 4-Kbyte units
  wire logic [16:0] progLimit = {1'b0, progCode, 12'h000};

  // Prohibited fast RAM codes fall back to the smaller size
  wire logic fastFull = (fastCode == `FAST_CODE_1024);
  wire logic [15:0] fastBase = fastFull ? `FAST_BASE_1024 : `FAST_BASE_512;

  // Prohibited expansion codes disable the expansion RAM
  wire logic extIsFull = (extCode == `EXT_CODE_FULL);
  wire logic extIsHalf = (extCode == `EXT_CODE_HALF);
  wire ext_mode_type extModeDec = extIsFull ? EXT_FULL :
                                  extIsHalf ? EXT_HALF : EXT_OFF;
  wire logic [15:0] extBase = extIsHalf ? `EXT_BASE_HALF : `EXT_BASE_FULL;
  wire logic extOn = extIsFull | extIsHalf;

  assign extMode = extModeDec;
  assign capacity.progLimit = progLimit;
  assign capacity.fastBase = fastBase;
  assign capacity.extBase = extBase;
  assign capacity.extOn = extOn;

  // Anything beyond the selected capacity is masked off
  assign progHit = ({1'b0, fetchAddr} < progLimit);
  assign fastMemHit = (dataAddr >= fastBase) & (dataAddr <= `FAST_MEM_TOP);
  assign extMemHit = extOn & (dataAddr >= extBase) & (dataAddr <= `EXT_MEM_TOP);

  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic pastRst_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pastRst_r <= 1'b1;
    end else begin
      pastRst_r <= 1'b0;
    end
  end

  mem_reset_value_a: assert property (
    $fell(pastRst_r) |-> $past(memSizeSel) == 8'hcf)
    else $error("memory size select not at reset value");

  ext_reset_value_a: assert property (
    $fell(pastRst_r) |-> $past(extSizeSel) == 8'h0a)
    else $error("expansion select not at reset value");

  mem_store_load_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff0
    |=> memSizeSel == ($past(cpuWr.data) & 8'hef))
    else $error("memory size select store not taken");

  mem_store_ignore_a: assert property (
    !(cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff0)
    |=> $stable(memSizeSel))
    else $error("memory size select changed without store");

  ext_store_load_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff4
    |=> extSizeSel == ($past(cpuWr.data) & 8'h0f))
    else $error("expansion select store not taken");

  ext_store_ignore_a: assert property (
    !(cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff4)
    |=> $stable(extSizeSel))
    else $error("expansion select changed without store");

  zero_bits_a: assert property (
    memSizeSel[4] == 1'b0 && extSizeSel[7:4] == 4'h0)
    else $error("fixed zero bit set");

  prog_limit_a: assert property (
    progHit == (fetchAddr < {memSizeSel[3:0], 12'h000}) ||
    (memSizeSel[3:0] == 4'h0 && !progHit))
    else $error("program memory qualifier wrong");

  fast_size_a: assert property (
    memSizeSel[7:5] == 3'h6 && dataAddr == 16'hfb00 |-> fastMemHit)
    else $error("1024-byte fast RAM not enabled");

  fast_small_a: assert property (
    memSizeSel[7:5] == 3'h2 && dataAddr == 16'hfcff |-> !fastMemHit)
    else $error("fast RAM above 512 bytes not disabled");

  ext_half_a: assert property (
    extSizeSel[3:0] == 4'hb |->
    extMemHit == (dataAddr >= 16'hf600 && dataAddr <= 16'hf7ff))
    else $error("half expansion RAM decode wrong");

  ext_off_a: assert property (
    extSizeSel[3:0] == 4'hc |-> !extMemHit && extMode == EXT_OFF)
    else $error("expansion RAM not disabled");

  new_setting_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff0 && cpuWr.data == 8'h42
    |=> capacity.progLimit == 17'h02000 && capacity.fastBase == 16'hfd00)
    else $error("new capacity not effective next cycle");

  mem_store_full_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff0 && cpuWr.data == 8'hcf
    |=> capacity.progLimit == 17'h0f000 && capacity.fastBase == 16'hfb00)
    else $error("full capacity not effective next cycle");

  ext_store_half_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff4 && cpuWr.data == 8'h0b
    |=> extMode == EXT_HALF && capacity.extBase == 16'hf600)
    else $error("half expansion not effective next cycle");

  ext_store_off_a: assert property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff4 && cpuWr.data == 8'h0c
    |=> extMode == EXT_OFF && !capacity.extOn)
    else $error("expansion off not effective next cycle");

  word_store_ignored_a: assert property (
    cpuWr.en && !cpuWr.byteOp
    |=> $stable(memSizeSel) && $stable(extSizeSel))
    else $error("word store changed a size register");

  reset_limit_a: assert property (
    $fell(pastRst_r)
    |-> $past(capacity.progLimit) == 17'h0f000)
    else $error("program limit not full after reset");

  reset_ext_mode_a: assert property (
    $fell(pastRst_r)
    |-> $past(extMode) == EXT_FULL)
    else $error("expansion mode not full after reset");

  prog_full_a: assert property (
    memSizeSel[3:0] == 4'hf && fetchAddr == 16'hefff
    |-> progHit)
    else $error("60-Kbyte program top not enabled");

  prog_top_off_a: assert property (
    memSizeSel[3:0] == 4'hf && fetchAddr == 16'hf000
    |-> !progHit)
    else $error("program memory above 60 Kbytes enabled");

  prog_8k_a: assert property (
    memSizeSel[3:0] == 4'h2
    |-> progHit == (fetchAddr < 16'h2000))
    else $error("8-Kbyte program decode wrong");

  prog_56k_a: assert property (
    memSizeSel[3:0] == 4'he
    |-> progHit == (fetchAddr < 16'he000))
    else $error("56-Kbyte program decode wrong");

  prog_hit_bound_a: assert property (
    fetchAddr >= 16'hf000
    |-> !progHit)
    else $error("program hit beyond largest capacity");

  prog_full_limit_a: assert property (
    memSizeSel[3:0] == 4'hf
    |-> capacity.progLimit == 17'h0f000)
    else $error("60-Kbyte limit wrong");

  fast_base_value_a: assert property (
    memSizeSel[7:5] == 3'h6
    |-> capacity.fastBase == 16'hfb00)
    else $error("1024-byte fast RAM base wrong");

  fast_1024_range_a: assert property (
    memSizeSel[7:5] == 3'h6
    |-> fastMemHit == (dataAddr >= 16'hfb00 && dataAddr <= 16'hfeff))
    else $error("1024-byte fast RAM decode wrong");

  fast_512_range_a: assert property (
    memSizeSel[7:5] == 3'h2
    |-> fastMemHit == (dataAddr >= 16'hfd00 && dataAddr <= 16'hfeff))
    else $error("512-byte fast RAM decode wrong");

  fast_top_hit_a: assert property (
    dataAddr == 16'hfeff
    |-> fastMemHit)
    else $error("fast RAM top not enabled");

  fast_above_a: assert property (
    dataAddr > 16'hfeff
    |-> !fastMemHit)
    else $error("fast RAM hit above its top");

  fast_below_a: assert property (
    dataAddr < 16'hfb00
    |-> !fastMemHit)
    else $error("fast RAM hit below largest base");

  ext_full_a: assert property (
    extSizeSel[3:0] == 4'ha
    |-> extMode == EXT_FULL && extMemHit == (dataAddr >= 16'hf400 && dataAddr <= 16'hf7ff))
    else $error("full expansion RAM decode wrong");

  ext_half_low_a: assert property (
    extSizeSel[3:0] == 4'hb && dataAddr == 16'hf5ff
    |-> !extMemHit)
    else $error("lower expansion half not disabled");

  ext_prohib_off_a: assert property (
    extSizeSel[3:0] != 4'ha && extSizeSel[3:0] != 4'hb
    |-> !capacity.extOn)
    else $error("prohibited expansion code enabled RAM");

  ext_above_a: assert property (
    dataAddr > 16'hf7ff
    |-> !extMemHit)
    else $error("expansion RAM hit above its top");

  ext_below_a: assert property (
    dataAddr < 16'hf400
    |-> !extMemHit)
    else $error("expansion RAM hit below its base");

  ext_onehot_a: assert property (
    $onehot(extMode))
    else $error("expansion mode not one-hot");

  emulate_small_c: cover property (
    cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff0 && cpuWr.data == 8'h42
    ##1 cpuWr.en && cpuWr.byteOp && cpuWr.addr == 16'hfff4 && cpuWr.data == 8'h0c);

  ext_half_c: cover property (extMode == EXT_HALF ##1 extMemHit);

  prog_edge_c: cover property (memSizeSel[3:0] == 4'he && fetchAddr == 16'hdfff && progHit);

  ignored_word_c: cover property (
    cpuWr.en && !cpuWr.byteOp && cpuWr.addr == 16'hfff0 ##1 $stable(memSizeSel));

  ext_switch_c: cover property (extMode == EXT_OFF ##1 extMode == EXT_HALF);

endmodule

`default_nettype wire

// >>> memory_size_config_regs_bench.sv
/*
  Self-checking bench for the memory size configuration registers.
  Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module memory_size_config_regs_bench
  import memory_size_config_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  cpu_write_type cpuWr = '0;
  logic [15:0] fetchAddr = 16'h0000;
  logic [15:0] dataAddr = 16'h0000;
  logic [7:0] memSizeSel;
  logic [7:0] extSizeSel;
  capacity_type capacity;
  ext_mode_type extMode;
  logic progHit;
  logic fastMemHit;
  logic extMemHit;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] memVals [7] = '{8'h42, 8'h44, 8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hcf};

  memory_size_config_regs u_memory_size_config_regs (
    .core_clk(core_clk),
    .rst(rst),
    .cpuWr(cpuWr),
    .fetchAddr(fetchAddr),
    .dataAddr(dataAddr),
    .memSizeSel(memSizeSel),
    .extSizeSel(extSizeSel),
    .capacity(capacity),
    .extMode(extMode),
    .progHit(progHit),
    .fastMemHit(fastMemHit),
    .extMemHit(extMemHit)
  );

  always #4 core_clk = ~core_clk;

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One store, launched and closed on falling edges
  task automatic store(input logic [15:0] a, input logic [7:0] d, input logic bo);
    @(negedge core_clk);
    cpuWr = '{en: 1'b1, byteOp: bo, addr: a, data: d};
    @(negedge core_clk);
    cpuWr.en = 1'b0;
  endtask

  task automatic chkMem(input logic [7:0] v);
    logic [16:0] lim;
    logic [15:0] fb;
    lim = {1'b0, v[3:0], 12'h000};
    fb = (v[7:5] == 3'h6) ? 16'hfb00 : 16'hfd00;
    `CHK(memSizeSel, v & 8'hef);
    `CHK(capacity.progLimit, lim);
    `CHK(capacity.fastBase, fb);
    @(negedge core_clk);
    fetchAddr = lim[15:0] - 16'h0001;
    #1;
    `CHK(progHit, 1'b1);
    @(negedge core_clk);
    fetchAddr = lim[15:0];
    #1;
    `CHK(progHit, 1'b0);
    @(negedge core_clk);
    dataAddr = fb;
    #1;
    `CHK(fastMemHit, 1'b1);
    @(negedge core_clk);
    dataAddr = fb - 16'h0001;
    #1;
    `CHK(fastMemHit, 1'b0);
  endtask

  task automatic chkExt(input logic [7:0] v, input ext_mode_type m, input logic [15:0] b,
                        input logic on);
    `CHK(extSizeSel, v & 8'h0f);
    `CHK(extMode, m);
    `CHK(capacity.extOn, on);
    @(negedge core_clk);
    dataAddr = b;
    #1;
    `CHK(extMemHit, on);
    @(negedge core_clk);
    dataAddr = b - 16'h0001;
    #1;
    `CHK(extMemHit, 1'b0);
    @(negedge core_clk);
    dataAddr = 16'hf800;
    #1;
    `CHK(extMemHit, 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chkMem(8'hcf);
    chkExt(8'h0a, EXT_FULL, 16'hf400, 1'b1);
    $display("test reset_values done");
    foreach (memVals[i]) begin
      store(16'hfff0, memVals[i], 1'b1);
      chkMem(memVals[i]);
    end
    store(16'hfff0, 8'hce, 1'b1);
    chkMem(8'hce);
    store(16'hfff0, 8'hff, 1'b1);
    chkMem(8'hff);
    $display("test memory_size done");
    store(16'hfff4, 8'h0c, 1'b1);
    chkExt(8'h0c, EXT_OFF, 16'hf400, 1'b0);
    store(16'hfff4, 8'h0b, 1'b1);
    chkExt(8'h0b, EXT_HALF, 16'hf600, 1'b1);
    `CHK(capacity.extBase, 16'hf600);
    store(16'hfff4, 8'h0a, 1'b1);
    chkExt(8'h0a, EXT_FULL, 16'hf400, 1'b1);
    store(16'hfff4, 8'hff, 1'b1);
    chkExt(8'hff, EXT_OFF, 16'hf400, 1'b0);
    $display("test expansion_size done");
    // Word stores, stray addresses and idle requests must all be ignored
    store(16'hfff0, 8'h42, 1'b0);
    store(16'hfff1, 8'h42, 1'b1);
    store(16'hfff4, 8'h0b, 1'b0);
    @(negedge core_clk);
    cpuWr = '{en: 1'b0, byteOp: 1'b1, addr: 16'hfff0, data: 8'h42};
    @(negedge core_clk);
    chkMem(8'hff);
    `CHK(extSizeSel, 8'h0f);
    $display("test refused_stores done");
    @(negedge core_clk);
    cpuWr = '{en: 1'b1, byteOp: 1'b1, addr: 16'hfff0, data: 8'h44};
    @(negedge core_clk);
    `CHK(memSizeSel, 8'h44);
    cpuWr = '{en: 1'b1, byteOp: 1'b1, addr: 16'hfff4, data: 8'h0b};
    @(negedge core_clk);
    cpuWr.en = 1'b0;
    `CHK(extSizeSel, 8'h0b);
    `CHK(memSizeSel, 8'h44);
    $display("test back_to_back done");
    rst = 1'b1;
    @(negedge core_clk);
    `CHK(memSizeSel, 8'hcf);
    `CHK(extSizeSel, 8'h0a);
    rst = 1'b0;
    store(16'hfff4, 8'h0c, 1'b1);
    `CHK(extSizeSel, 8'h0c);
    `CHK(memSizeSel, 8'hcf);
    $display("test second_reset done");
    close_out();
  end

  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule

`default_nettype wire
